// *** logic/gesc_top.sv ***
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
module gesc_top
  import gesc_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  input  wire logic              i_exit_start,
  input  wire logic              i_sysmgmt_exit,
  input  wire gesc_guest_s       i_cpu_state,
  input  wire gesc_decode_s      i_decode,
  output logic                   o_capture_done,
  output gesc_guest_s            o_guest_state,
  output logic [31:0]            o_exit_instruction_detail,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  gesc_guest_s  guest_r;
  gesc_guest_s  guest_nxt;
  logic [31:0]  detail_r;
  logic [31:0]  detail_nxt;
  logic         done_r;
  logic         valid_r;
  logic [7:0]   exit_cnt_r;
  logic [2:0]   exit_ctrl_r;
  logic [5:0]   field_sel_r;
  logic [31:0]  prdata_r;

  // ----------------------------------------------------------------------
  // Detail word encoding
  // ----------------------------------------------------------------------
  wire logic       mem_form   = ~i_decode.is_reg;
  wire logic       scale_ok   = mem_form & i_decode.index_valid;
  wire logic       asz_ok     = mem_form & (i_decode.addr_size != ASZ_UNUSED);
  wire logic [1:0] scale_code = (scale_ok && (LONG_CAPABLE || i_decode.scale != 2'h3))
                                ? i_decode.scale : 2'h0;
  wire logic [3:0] first_code = i_decode.is_reg ? i_decode.first_reg_operand
                                                : 4'h0;
  wire logic [2:0] asz_code   = asz_ok ? {1'b0, i_decode.addr_size} : 3'h0;
  wire logic [2:0] seg_code   = (mem_form && i_decode.segment <= 3'h5)
                                ? i_decode.segment : 3'h0;
  wire logic [3:0] idx_code   = scale_ok ? i_decode.index_register_field
                                         : 4'h0;
  wire logic       idx_none   = mem_form & ~i_decode.index_valid;
  wire logic       base_ok    = mem_form & i_decode.base_valid;
  wire logic [3:0] base_code  = base_ok ? i_decode.base_register_field : 4'h0;
  wire logic       base_none  = mem_form & ~i_decode.base_valid;

  always_comb begin
    detail_nxt                              = 32'h0000_0000;
    if (i_decode.field_op) begin
      detail_nxt[DW_SCALE_LO +: 2]          = scale_code;
      detail_nxt[DW_FIRST_LO +: 4]          = first_code;
      detail_nxt[DW_ASZ_LO +: 3]            = asz_code;
      detail_nxt[DW_IS_REG]                 = i_decode.is_reg;
      detail_nxt[DW_SEG_LO +: 3]            = seg_code;
      detail_nxt[DW_IDX_LO +: 4]            = idx_code;
      detail_nxt[DW_IDX_NONE]               = idx_none;
      detail_nxt[DW_BASE_LO +: 4]           = base_code;
      detail_nxt[DW_BASE_NONE]              = base_none;
      detail_nxt[DW_SECOND_LO +: 4]         = i_decode.second_reg_operand;
    end
  end

  // ----------------------------------------------------------------------
  // Segment save, one slot per segment register
  // ----------------------------------------------------------------------
  gesc_seg_s seg_sv [SEG_NUM];

  for (genvar g = 0; g < SEG_NUM; g++) begin : g_seg
    gesc_seg_s   raw;
    logic        unus;
    logic [63:0] base_v;
    logic [31:0] limit_v;
    logic [31:0] ar_v;
    assign raw  = i_cpu_state.seg[g];
    assign unus = raw.ar[AR_UNUSABLE];

    always_comb begin
      // Undefined parts of an unusable segment are zeroed for repeatability
      base_v  = unus ? 64'h0 : raw.base;
      limit_v = unus ? 32'h0 : raw.limit;
      ar_v    = unus ? 32'h0 : (raw.ar & AR_KEEP_MASK);
      if (g == SEG_CS && unus) begin
        base_v           = raw.base;
        limit_v          = raw.limit;
        ar_v[AR_LONG]    = raw.ar[AR_LONG];
        ar_v[AR_DSIZE]   = raw.ar[AR_DSIZE];
        ar_v[AR_GRAN]    = raw.ar[AR_GRAN];
      end
      if (g == SEG_SS && unus) begin
        ar_v[AR_PRIV_LO +: 2] = raw.ar[AR_PRIV_LO +: 2];
      end
      if ((g == SEG_SS || g == SEG_DS || g == SEG_ES) && LONG_CAPABLE) begin
        base_v[63:32] = 32'h0;
      end
      if (g == SEG_FS || g == SEG_GS) begin
        base_v = raw.base;
      end
      if (g == SEG_LDT) begin
        base_v[63:48] = {16{base_v[47]}};
      end
      ar_v[31:17]       = 15'h0000;
      ar_v[11:8]        = 4'h0;
      ar_v[AR_UNUSABLE] = unus;
    end

    assign seg_sv[g] = '{base: base_v, limit: limit_v, ar: ar_v};
  end

  // ----------------------------------------------------------------------
  // Guest-state next value
  // ----------------------------------------------------------------------
  // Fields whose save control is clear keep the value from the last exit.
  always_comb begin
    guest_nxt                         = guest_r;
    guest_nxt.control_reg_zero        = i_cpu_state.control_reg_zero;
    guest_nxt.control_reg_three       = i_cpu_state.control_reg_three;
    guest_nxt.control_reg_four        = i_cpu_state.control_reg_four;
    guest_nxt.fast_call_selector_reg  = i_cpu_state.fast_call_selector_reg;
    guest_nxt.fast_call_stack_reg     = i_cpu_state.fast_call_stack_reg;
    guest_nxt.fast_call_entry_reg     = i_cpu_state.fast_call_entry_reg;
    if (!LONG_CAPABLE) begin
      guest_nxt.fast_call_stack_reg[63:32] = 32'h0;
      guest_nxt.fast_call_entry_reg[63:32] = 32'h0;
    end
    if (exit_ctrl_r[CTRL_SAVE_DBG]) begin
      guest_nxt.debug_control_reg       = i_cpu_state.debug_control_reg;
      guest_nxt.debug_control_model_reg = i_cpu_state.debug_control_model_reg;
    end
    if (exit_ctrl_r[CTRL_SAVE_PAGE]) begin
      guest_nxt.page_attribute_reg    = i_cpu_state.page_attribute_reg;
    end
    if (exit_ctrl_r[CTRL_SAVE_FEAT]) begin
      guest_nxt.extended_feature_reg  = i_cpu_state.extended_feature_reg;
    end
    guest_nxt.sysmgmt_base_field      = i_sysmgmt_exit ? i_cpu_state.sysmgmt_base_field
                                                       : 32'h0;
    guest_nxt.global_descriptor_table_reg    =
      i_cpu_state.global_descriptor_table_reg;
    guest_nxt.interrupt_descriptor_table_reg =
      i_cpu_state.interrupt_descriptor_table_reg;
    for (int s = 0; s < SEG_NUM; s++) begin
      guest_nxt.seg[s]                = seg_sv[s];
    end
  end

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  // Sampling on the start edge freezes state before any exit-side update.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      guest_r    <= '0;
      detail_r   <= 32'h0000_0000;
      done_r     <= 1'b0;
      valid_r    <= 1'b0;
      exit_cnt_r <= 8'h00;
    end else begin
      done_r <= i_exit_start;
      if (i_exit_start) begin
        guest_r    <= guest_nxt;
        detail_r   <= detail_nxt;
        valid_r    <= 1'b1;
        exit_cnt_r <= exit_cnt_r + 8'h01;
      end
    end
  end

  assign o_guest_state             = guest_r;
  assign o_exit_instruction_detail = detail_r;
  assign o_capture_done            = done_r;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Read data is latched in the setup cycle so the access phase never waits.
  localparam int FLAT_W = GUEST_WORDS * 32;

  wire logic [FLAT_W-1:0] guest_flat = FLAT_W'(guest_r);
  wire logic              hit_detail = (i_paddr == OFS_DETAIL);
  wire logic              hit_ctrl   = (i_paddr == OFS_EXIT_CTRL);
  wire logic              hit_status = (i_paddr == OFS_STATUS);
  wire logic              hit_sel    = (i_paddr == OFS_FIELD_SEL);
  wire logic              hit_data   = (i_paddr == OFS_FIELD_DATA);
  wire logic              hit_any    = hit_detail | hit_ctrl | hit_status
                                     | hit_sel | hit_data;
  wire logic              sel_ok     = (32'(field_sel_r) < GUEST_WORDS);
  wire logic [31:0]       field_word = sel_ok ? guest_flat[32'(field_sel_r) * 32 +: 32]
                                              : 32'h0000_0000;
  wire logic              setup      = i_psel & ~i_penable;
  wire logic              wr_acc     = i_psel & i_penable & i_pwrite & hit_any;
  wire logic [31:0]       rd_mux     = hit_detail ? detail_r
                                     : hit_ctrl   ? {29'h0, exit_ctrl_r}
                                     : hit_status ? {16'h0, exit_cnt_r, 7'h00, valid_r}
                                     : hit_sel    ? {26'h0, field_sel_r}
                                     : hit_data   ? field_word
                                     : 32'h0000_0000;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      exit_ctrl_r <= EXIT_CTRL_RST;
      field_sel_r <= FIELD_SEL_RST;
      prdata_r    <= 32'h0000_0000;
    end else begin
      if (setup) begin
        prdata_r <= rd_mux;
      end
      if (wr_acc && hit_ctrl) begin
        exit_ctrl_r <= i_pwdata[2:0];
      end
      if (wr_acc && hit_sel) begin
        field_sel_r <= i_pwdata[5:0];
      end
    end
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit_any;

endmodule : gesc_top

// *** shared/gesc_pkg.sv ***
package gesc_pkg;

  // ----------------------------------------------------------------------
  // Part capability
  // ----------------------------------------------------------------------
  localparam logic        LONG_CAPABLE   = 1'b1;

  // ----------------------------------------------------------------------
  // APB register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] OFS_DETAIL     = 12'h000;
  localparam logic [11:0] OFS_EXIT_CTRL  = 12'h004;
  localparam logic [11:0] OFS_STATUS     = 12'h008;
  localparam logic [11:0] OFS_FIELD_SEL  = 12'h00C;
  localparam logic [11:0] OFS_FIELD_DATA = 12'h010;

  localparam logic [2:0]  EXIT_CTRL_RST  = 3'h7;
  localparam int          CTRL_SAVE_DBG  = 0;
  localparam int          CTRL_SAVE_PAGE = 1;
  localparam int          CTRL_SAVE_FEAT = 2;
  localparam logic [5:0]  FIELD_SEL_RST  = 6'h00;

  // ----------------------------------------------------------------------
  // Detail word layout
  // ----------------------------------------------------------------------
  localparam int          DW_SCALE_LO    = 0;
  localparam int          DW_FIRST_LO    = 3;
  localparam int          DW_ASZ_LO      = 7;
  localparam int          DW_IS_REG      = 10;
  localparam int          DW_SEG_LO      = 15;
  localparam int          DW_IDX_LO      = 18;
  localparam int          DW_IDX_NONE    = 22;
  localparam int          DW_BASE_LO     = 23;
  localparam int          DW_BASE_NONE   = 27;
  localparam int          DW_SECOND_LO   = 28;
  localparam logic [1:0]  ASZ_UNUSED     = 2'h3;

  // ----------------------------------------------------------------------
  // Access-rights layout
  // ----------------------------------------------------------------------
  localparam int          AR_UNUSABLE    = 16;
  localparam int          AR_PRIV_LO     = 5;
  localparam int          AR_LONG        = 13;
  localparam int          AR_DSIZE       = 14;
  localparam int          AR_GRAN        = 15;
  localparam logic [31:0] AR_KEEP_MASK   = 32'h0000_F0FF;

  // Segment slots
  localparam int          SEG_ES = 0;
  localparam int          SEG_CS = 1;
  localparam int          SEG_SS = 2;
  localparam int          SEG_DS = 3;
  localparam int          SEG_FS = 4;
  localparam int          SEG_GS = 5;
  localparam int          SEG_LDT = 6;
  localparam int          SEG_NUM = 8;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [63:0] base;
    logic [31:0] limit;
    logic [31:0] ar;
  } gesc_seg_s;

  typedef struct packed {
    logic [63:0] base;
    logic [31:0] limit;
  } gesc_dtr_s;

  typedef struct packed {
    logic [63:0]               control_reg_zero;
    logic [63:0]               control_reg_three;
    logic [63:0]               control_reg_four;
    logic [63:0]               debug_control_reg;
    logic [63:0]               debug_control_model_reg;
    logic [63:0]               page_attribute_reg;
    logic [63:0]               extended_feature_reg;
    logic [63:0]               fast_call_stack_reg;
    logic [63:0]               fast_call_entry_reg;
    logic [31:0]               fast_call_selector_reg;
    logic [31:0]               sysmgmt_base_field;
    gesc_dtr_s                 global_descriptor_table_reg;
    gesc_dtr_s                 interrupt_descriptor_table_reg;
    gesc_seg_s [SEG_NUM-1:0]   seg;
  } gesc_guest_s;

  typedef struct packed {
    logic       field_op;
    logic       is_reg;
    logic [1:0] scale;
    logic [3:0] first_reg_operand;
    logic [1:0] addr_size;
    logic [2:0] segment;
    logic [3:0] index_register_field;
    logic       index_valid;
    logic [3:0] base_register_field;
    logic       base_valid;
    logic [3:0] second_reg_operand;
  } gesc_decode_s;

  localparam int          GUEST_BITS     = $bits(gesc_guest_s);
  localparam int          GUEST_WORDS    = (GUEST_BITS + 31) / 32;

endpackage : gesc_pkg

// *** testbench/gesc_monitor.sv ***
`timescale 1ns/100ps
module gesc_monitor
  import gesc_pkg::*;
(
  input wire logic              i_clk_sys,
  input wire logic              i_sys_rst,
  input wire logic              i_exit_start,
  input wire logic              i_sysmgmt_exit,
  input wire gesc_guest_s       i_cpu_state,
  input wire gesc_decode_s      i_decode,
  input wire logic              o_capture_done,
  input wire gesc_guest_s       o_guest_state,
  input wire logic [31:0]       o_exit_instruction_detail,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr
);
  wire logic [31:0] dw = o_exit_instruction_detail;
  wire gesc_guest_s og = o_guest_state;
  wire gesc_guest_s ic = i_cpu_state;
  wire gesc_decode_s dc = i_decode;
  wire logic        fm = i_exit_start && dc.field_op && !dc.is_reg;
  wire logic        fr = i_exit_start && dc.field_op && dc.is_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_done_pulse: assert property (1'b1 |=> o_capture_done == $past(i_exit_start))
    else $error("done pulse mismatch");
  a_loose_zero: assert property (dw[2] == 1'b0 && dw[14:11] == 4'h0)
    else $error("loose detail bits set");
  a_reg_form: assert property (fr |=> dw[10]
    && dw[6:3] == $past(dc.first_reg_operand)
    && dw[31:28] == $past(dc.second_reg_operand)
    && {dw[27:11], dw[9:7], dw[1:0]} == '0)
    else $error("register form detail wrong");
  a_mem_form: assert property (fm |=> !dw[10]
    && dw[22] == !$past(dc.index_valid)
    && dw[27] == !$past(dc.base_valid))
    else $error("memory form flags wrong");
  a_scale_index: assert property (fm && dc.index_valid |=>
    dw[1:0] == $past(dc.scale)
    && dw[21:18] == $past(dc.index_register_field))
    else $error("scale or index wrong");
  a_addr_seg: assert property (fm |=>
    dw[9:7] == ($past(dc.addr_size) == 2'h3 ? 3'h0 : {1'b0, $past(dc.addr_size)})
    && dw[17:15] == ($past(dc.segment) > 3'h5 ? 3'h0 : $past(dc.segment)))
    else $error("address size or segment wrong");
  a_ctrl_saved: assert property (i_exit_start |=>
    og.control_reg_zero == $past(ic.control_reg_zero)
    && og.control_reg_three == $past(ic.control_reg_three)
    && og.control_reg_four == $past(ic.control_reg_four)
    && og.fast_call_entry_reg == $past(ic.fast_call_entry_reg)
    && og.global_descriptor_table_reg == $past(ic.global_descriptor_table_reg))
    else $error("control state not saved");
  a_mgmt_base: assert property (i_exit_start |=> og.sysmgmt_base_field ==
    ($past(i_sysmgmt_exit) ? $past(ic.sysmgmt_base_field) : 32'h0))
    else $error("management base wrong");
  a_cs_kept: assert property (i_exit_start |=>
    og.seg[SEG_CS].base == $past(ic.seg[SEG_CS].base)
    && og.seg[SEG_CS].ar[15:13] == $past(ic.seg[SEG_CS].ar[15:13]))
    else $error("code segment not kept");
  a_upper_zero: assert property (
    og.seg[SEG_DS].base[63:32] == 32'h0 && og.seg[SEG_SS].base[63:32] == 32'h0
    && og.seg[SEG_ES].base[63:32] == 32'h0)
    else $error("base upper half set");
  for (genvar k = 0; k < SEG_NUM; k++) begin : g_seg
    a_ar_marks: assert property (i_exit_start |=> og.seg[k].ar[31:8] ==
      {15'h0, $past(ic.seg[k].ar[16]), og.seg[k].ar[15:12], 4'h0})
      else $error("access rights fixed bits wrong");
  end
  c_reg_form: cover property (fr);
  c_mem_form: cover property (fm && dc.index_valid);
  c_cs_unusable: cover property (i_exit_start && ic.seg[SEG_CS].ar[AR_UNUSABLE]);
  c_mgmt_exit: cover property (i_exit_start && i_sysmgmt_exit);
endmodule : gesc_monitor

bind gesc_top gesc_monitor mon_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_exit_start(i_exit_start), .i_sysmgmt_exit(i_sysmgmt_exit), .i_cpu_state(i_cpu_state),
  .i_decode(i_decode), .o_capture_done(o_capture_done), .o_guest_state(o_guest_state),
  .o_exit_instruction_detail(o_exit_instruction_detail), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

// *** testbench/guest_exit_state_capture_tb.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module guest_exit_state_capture_tb
  import gesc_pkg::*;
;
  logic i_clk_sys = 0, i_sys_rst = 1, i_exit_start = 0, i_sysmgmt_exit = 0;
  logic i_psel = 0, i_penable = 0, i_pwrite = 0, o_capture_done, o_pready, o_pslverr;
  logic [ADDR_W-1:0] i_paddr = '0;
  logic [31:0]       i_pwdata = '0, o_prdata, o_exit_instruction_detail;
  gesc_guest_s       i_cpu_state = '0, o_guest_state, em = '0;
  gesc_decode_s      i_decode = '0;
  int                miscompares = 0, compares = 0, nexit = 0;
  logic [31:0]       seed = 32'hE5F70AF0, rd, r, ed = '0;
  logic              err, pend = 0;
  logic [2:0]        ctl = 3'h7;

  always #5 i_clk_sys = ~i_clk_sys;

  gesc_top dut_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_exit_start(i_exit_start),
    .i_sysmgmt_exit(i_sysmgmt_exit), .i_cpu_state(i_cpu_state), .i_decode(i_decode),
    .o_capture_done(o_capture_done), .o_guest_state(o_guest_state),
    .o_exit_instruction_detail(o_exit_instruction_detail), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic gesc_guest_s rnd_state();
    logic [GUEST_WORDS*32-1:0] v;
    for (int i = 0; i < GUEST_WORDS; i++) v[i*32 +: 32] = rnd();
    return v[GUEST_BITS-1:0];
  endfunction : rnd_state

  function automatic logic [31:0] exp_detail(gesc_decode_s d);
    logic [31:0] w;
    w = '0;
    if (d.field_op) begin
      w[10] = d.is_reg;
      w[31:28] = d.second_reg_operand;
      if (d.is_reg) w[6:3] = d.first_reg_operand;
      else begin
        w[9:7] = (d.addr_size == 2'h3) ? 3'h0 : {1'b0, d.addr_size};
        w[17:15] = (d.segment > 3'h5) ? 3'h0 : d.segment;
        w[22] = !d.index_valid;
        w[27] = !d.base_valid;
        if (d.index_valid) w[21:18] = d.index_register_field;
        if (d.index_valid) w[1:0] = d.scale;
        if (d.base_valid) w[26:23] = d.base_register_field;
      end
    end
    return w;
  endfunction : exp_detail

  // Dropped fields are expected to keep the last capture; the management base is expected as zero unless mgmt is set
  function automatic gesc_guest_s exp_state(gesc_guest_s s, gesc_guest_s p, logic mgmt);
    gesc_guest_s e;
    logic u;
    e = s;
    if (!ctl[CTRL_SAVE_DBG]) e.debug_control_reg = p.debug_control_reg;
    if (!ctl[CTRL_SAVE_DBG]) e.debug_control_model_reg = p.debug_control_model_reg;
    if (!ctl[CTRL_SAVE_PAGE]) e.page_attribute_reg = p.page_attribute_reg;
    if (!ctl[CTRL_SAVE_FEAT]) e.extended_feature_reg = p.extended_feature_reg;
    if (!mgmt) e.sysmgmt_base_field = '0;
    for (int k = 0; k < SEG_NUM; k++) begin
      u = s.seg[k].ar[AR_UNUSABLE];
      e.seg[k].ar = s.seg[k].ar & AR_KEEP_MASK;
      e.seg[k].ar[AR_UNUSABLE] = u;
      if (u) begin
        e.seg[k].ar[7:0] = 8'h00;
        e.seg[k].ar[15:12] = 4'h0;
        if (k != SEG_CS) e.seg[k].limit = '0;
        if (k != SEG_CS && k != SEG_FS && k != SEG_GS) e.seg[k].base = '0;
        if (k == SEG_CS) e.seg[k].ar[15:13] = s.seg[k].ar[15:13];
        if (k == SEG_SS) e.seg[k].ar[6:5] = s.seg[k].ar[6:5];
      end
      if (k == SEG_ES || k == SEG_SS || k == SEG_DS) e.seg[k].base[63:32] = '0;
    end
    e.seg[SEG_LDT].base[63:48] = {16{e.seg[SEG_LDT].base[47]}};
    return e;
  endfunction : exp_state

  function automatic logic [31:0] fword(logic [5:0] k);
    logic [GUEST_WORDS*32-1:0] v;
    v = '0;
    v[GUEST_BITS-1:0] = em;
    return (k < GUEST_WORDS) ? v[k*32 +: 32] : 32'h0;
  endfunction : fword

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    @(posedge i_clk_sys);
    // No local limit: a slave that never answers is caught by the watchdog
    while (o_pready !== 1'b1) begin
      @(posedge i_clk_sys);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask : apb

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd & m)
  endtask : rchk

  // Fresh random state every cycle, so a late sample is caught
  task automatic fire(input logic go);
    gesc_guest_s s, ns;
    gesc_decode_s d;
    logic [31:0] nd, q;
    s = rnd_state();
    q = rnd();
    d = q[$bits(gesc_decode_s)-1:0];
    ns = go ? exp_state(s, em, q[31]) : em;
    nd = go ? exp_detail(d) : ed;
    i_exit_start <= go;
    i_cpu_state <= s;
    i_decode <= d;
    i_sysmgmt_exit <= q[31];
    @(posedge i_clk_sys);
    `CHK("done", pend, o_capture_done)
    `CHK("detail", ed, o_exit_instruction_detail)
    `CHK("state", em, o_guest_state)
    `CHK("seg_low", em.seg[3:0], o_guest_state.seg[3:0])
    `CHK("seg_high", em.seg[7:4], o_guest_state.seg[7:4])
    pend = go;
    em = ns;
    ed = nd;
    if (go) nexit++;
  endtask : fire

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rchk(OFS_DETAIL, 32'hFFFFFFFF, 32'h0, "detail_rst");
    rchk(OFS_EXIT_CTRL, 32'h7, 32'h7, "ctrl_rst");
    apb(1'b1, OFS_DETAIL, 32'hFFFFFFFF);
    rchk(OFS_DETAIL, 32'hFFFFFFFF, 32'h0, "detail_ro");
    rchk(12'hFFC, 32'hFFFFFFFF, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, err)
    for (int c = 0; c < 8; c++) begin
      ctl = 3'(c);
      apb(1'b1, OFS_EXIT_CTRL, {29'h0, ctl});
      repeat (12) begin
        r = rnd();
        fire(r[0] | r[1]);
      end
      fire(1'b1);
      fire(1'b1);
      fire(1'b0);
      fire(1'b0);
      rchk(OFS_DETAIL, 32'hFFFFFFFF, ed, "detail");
      r = rnd();
      apb(1'b1, OFS_FIELD_SEL, {26'h0, r[5:0]});
      rchk(OFS_FIELD_DATA, 32'hFFFFFFFF, fword(r[5:0]), "field");
      rchk(OFS_STATUS, 32'h0000FF01, {16'h0, nexit[7:0], 8'h01}, "status");
    end
    complete_run();
  end
endmodule : guest_exit_state_capture_tb
